// ---- rtl/sdram_cal_map.vh ----
// Constants for the bank, read and calibration-pattern logic
`ifndef SDRAM_CAL_MAP_VH
`define SDRAM_CAL_MAP_VH
// ==========================================
// Register offsets (APB byte addresses)
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_BANK_OPEN   8'h08
`define OFF_ROW_SEL     8'h0C
`define OFF_ROW_DATA    8'h10
`define OFF_ERR_COUNT   8'h14
// ==========================================
// Control field positions
`define CTRL_CL_LSB     0
`define CTRL_AL_LSB     4
`define CTRL_BL_LSB     8
`define CTRL_PAT_BIT    10
`define CTRL_LOC_LSB    11
`define CTRL_RESET      32'h0000_0006
// ==========================================
// Command encodings {cs_b, ras_b, cas_b, we_b}
`define CMD_MRS         4'h0
`define CMD_PRE         4'h2
`define CMD_ACT         4'h3
`define CMD_RD          4'h5
`define CMD_WR          4'h4
// Mode register address and fields
`define MR_THREE        3'h3
`define MR_ZERO         3'h0
`define MR3_EN_BIT      2
`define AP_BIT          10
`define BC_BIT          12
// Burst length field codes
`define BL_FIXED8       2'h0
`define BL_OTF          2'h1
// Column-to-column delay for a chopped burst
`define CCD_CHOP        4'h4
`endif

// ---- rtl/read_burst_engine.v ----
// Read burst queue and data launcher
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cal_map.vh"
module read_burst_engine #(
  parameter DEPTH_LOG = 2
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // Read command in
  input  wire        rd_push,
  input  wire [4:0]  rd_latency,
  input  wire        rd_full8,
  input  wire        rd_upper,
  input  wire        rd_pattern,
  // Data out
  output reg         dq_oe,
  output reg  [15:0] dq_out,
  output reg         dqs_out
);
  localparam DEPTH = 1 << DEPTH_LOG;
  // Queue entries: launch countdown, length, nibble, pattern flag
  reg [4:0]           cnt_q [0:DEPTH-1];
  reg [DEPTH-1:0]     full8_q, upper_q, pat_q, valid_q;
  reg [DEPTH_LOG-1:0] wr_q, rd_q;
  reg [2:0]           beat_q;
  reg                 busy_q, cur8_q, curp_q;
  integer i;
  // ==========================================
  // Queue and countdown, launch in command order
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      valid_q <= {DEPTH{1'b0}};
      wr_q    <= {DEPTH_LOG{1'b0}};
      rd_q    <= {DEPTH_LOG{1'b0}};
      busy_q  <= 1'b0;
      beat_q  <= 3'h0;
      cur8_q  <= 1'b0;
      curp_q  <= 1'b0;
      dq_oe   <= 1'b0;
      dq_out  <= 16'h0000;
      dqs_out <= 1'b0;
      full8_q <= {DEPTH{1'b0}};
      upper_q <= {DEPTH{1'b0}};
      pat_q   <= {DEPTH{1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) cnt_q[i] <= 5'h00;
    end else begin
      for (i = 0; i < DEPTH; i = i + 1)
        if (valid_q[i] && cnt_q[i] != 5'h00) cnt_q[i] <= cnt_q[i] - 5'h01;
      if (rd_push) begin // see RQ25
        cnt_q[wr_q]   <= rd_latency - 5'h01;
        full8_q[wr_q] <= rd_full8;
        upper_q[wr_q] <= rd_upper;
        pat_q[wr_q]   <= rd_pattern;
        valid_q[wr_q] <= 1'b1;
        wr_q          <= wr_q + 1'b1;
      end
      dqs_out <= 1'b0;
      if (busy_q) begin
        beat_q <= beat_q + 3'h1;
        busy_q <= !((cur8_q && beat_q == 3'h7) || (!cur8_q && beat_q[1:0] == 2'h3));
        // Last beat still drives; the idle cycle after it drops the enable
        dq_oe  <= 1'b1;
        // Alternating pattern repeated on all lane bits, array data as beat index
        dq_out <= curp_q ? {16{beat_q[0]}} : {13'h0000, beat_q}; // see RQ20 RQ21
        dqs_out <= ~beat_q[0];
      end else if (valid_q[rd_q] && cnt_q[rd_q] == 5'h00) begin // see RQ6
        busy_q  <= 1'b1;
        cur8_q  <= full8_q[rd_q];
        curp_q  <= pat_q[rd_q];
        beat_q  <= {upper_q[rd_q] & ~full8_q[rd_q], 2'h1}; // see RQ23
        dq_oe   <= 1'b1;
        dq_out  <= pat_q[rd_q] ? 16'h0000 : {13'h0000, upper_q[rd_q] & ~full8_q[rd_q], 2'h0};
        dqs_out <= 1'b1;
        valid_q[rd_q] <= rd_push && (wr_q == rd_q);
        rd_q    <= rd_q + 1'b1;
      end else
        dq_oe <= 1'b0;
    end
  end
endmodule // read_burst_engine
`default_nettype wire

// ---- rtl/sdram_bank_read_calibration.v ----
// Device-side command decoder, bank tracker and calibration-pattern mode
// Summary of operation
// RQ1: Controller precharges all banks and waits precharge period before pattern mode.
// RQ2: Mode register three write, enable 1, location 00, redirects reads to pattern.
// RQ3: Controller waits mode-set gap and update delay before first pattern read.
// RQ4: No writes while pattern mode is enabled.
// RQ5: Full pattern read uses column bits 2..0 zero and eight-beat burst.
// RQ6: Pattern burst starts after read latency, additive plus CAS latency.
// RQ7: Controller repeats pattern reads until capture is tuned.
// RQ8: After recovery, writing enable 0 returns accesses to the array.
// RQ9: Controller waits gap and update delay before regular commands again.
// RQ10: Activate opens row in selected bank until precharged.
// RQ11: Precharge a bank before opening another row there.
// RQ12: Precharge closes one or all banks; reuse after precharge period.
// RQ13: Concurrent auto precharge allows access to other banks.
// RQ14: Idle bank needs activate before read or write.
// RQ15: Precharge to idle or precharging bank accepted; period restarts.
// RQ16: Chop bit 0 gives four beats, 1 gives eight beats.
// RQ17: Eight beats when length field 00, or 01 with chop bit high.
// RQ18: Read to precharge spacing is additive latency plus read-to-precharge delay.
// RQ19: Reactivate only after precharge period and row cycle time.
// RQ20: Pattern beats alternate starting with 0.
// RQ21: Bit zero per lane carries pattern; other bits repeat it.
// RQ22: Read with auto precharge acts as plain read in pattern mode.
// RQ23: Chopped pattern read, column bit 2 picks lower or upper nibble.
// RQ24: Each bank tracked idle or open; illegal commands flagged.
// RQ25: Read launch timed by counter, bursts queued in command order.
`timescale 1ns/1ps
`default_nettype none
`include "sdram_cal_map.vh"
module sdram_bank_read_calibration #(
  parameter BANKS  = 8,
  parameter ROW_W  = 14,
  parameter T_RP   = 4'h6
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst_b,
  // Memory command pins
  input  wire        cs_b,
  input  wire        ras_b,
  input  wire        cas_b,
  input  wire        we_b,
  input  wire [2:0]  bank_select,
  input  wire [13:0] addr,
  // Read data pins
  output wire        dq_oe,
  output wire [15:0] dq_out,
  output wire        dqs_out,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Illegal command flag
  output reg         cmd_error
);
  // ==========================================
  // Pin synchronisers
  reg [20:0] pin_m_q, pin_s_q;
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_m_q <= 21'h1E0000;
      pin_s_q <= 21'h1E0000;
    end else begin
      pin_m_q <= {cs_b, ras_b, cas_b, we_b, bank_select, addr};
      pin_s_q <= pin_m_q;
    end
  end
  wire [3:0]  cmd  = pin_s_q[20:17];
  wire [2:0]  ba   = pin_s_q[16:14];
  wire [13:0] a    = pin_s_q[13:0];
  // ==========================================
  // State
  reg [31:0]        ctrl_q;      // CAS, additive latency, length field
  reg [BANKS-1:0]   open_q;
  reg [ROW_W-1:0]   row_q [0:BANKS-1];
  reg [3:0]         rp_q  [0:BANKS-1];
  reg [2:0]         row_sel_q;
  reg [15:0]        err_cnt_q;
  integer k;
  wire [3:0] cas_latency     = ctrl_q[`CTRL_CL_LSB +: 4];
  wire [3:0] additive_latency = ctrl_q[`CTRL_AL_LSB +: 4];
  wire [1:0] bl_field        = ctrl_q[`CTRL_BL_LSB +: 2];
  wire       pat_en          = ctrl_q[`CTRL_PAT_BIT];
  wire [1:0] pat_loc         = ctrl_q[`CTRL_LOC_LSB +: 2];
  wire [4:0] read_latency_cycles = {1'b0, additive_latency} + {1'b0, cas_latency}; // see RQ6
  // Eight-beat selection
  wire full8 = (bl_field == `BL_FIXED8) ||
               (bl_field == `BL_OTF && a[`BC_BIT]); // see RQ16 RQ17
  wire is_rd = (cmd == `CMD_RD);
  wire pat_rd = pat_en && (pat_loc == 2'h0); // see RQ2
  // Illegal: read (outside pattern mode) or write to idle bank, activate of open or precharging bank, write in pattern mode
  wire illegal = (is_rd && !pat_en && !open_q[ba]) ||
                 (cmd == `CMD_WR && (pat_en || !open_q[ba])) ||
                 (cmd == `CMD_ACT && (open_q[ba] || rp_q[ba] != 4'h0)); // see RQ24 RQ4 RQ14
  wire apb_wr = psel && penable && pwrite && pready;
  // ==========================================
  // Command decoder and bank tracker
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q    <= `CTRL_RESET;
      open_q    <= {BANKS{1'b0}};
      cmd_error <= 1'b0;
      err_cnt_q <= 16'h0000;
      for (k = 0; k < BANKS; k = k + 1) begin
        row_q[k] <= {ROW_W{1'b0}};
        rp_q[k]  <= 4'h0;
      end
    end else begin
      cmd_error <= illegal;
      if (illegal) err_cnt_q <= err_cnt_q + 16'h0001;
      for (k = 0; k < BANKS; k = k + 1)
        if (rp_q[k] != 4'h0) rp_q[k] <= rp_q[k] - 4'h1;
      // Software may preset latencies and mode
      if (apb_wr && paddr == `OFF_CTRL) ctrl_q <= pwdata;
      if (cmd == `CMD_MRS && ba == `MR_THREE) begin // see RQ2 RQ8
        ctrl_q[`CTRL_PAT_BIT] <= a[`MR3_EN_BIT];
        ctrl_q[`CTRL_LOC_LSB +: 2] <= a[1:0];
      end
      if (cmd == `CMD_MRS && ba == `MR_ZERO)
        ctrl_q[`CTRL_BL_LSB +: 2] <= a[1:0];
      if (cmd == `CMD_ACT && !illegal) begin // see RQ10
        open_q[ba] <= 1'b1;
        row_q[ba]  <= a[ROW_W-1:0];
      end
      // Single or all-bank precharge, period restarts each time
      if (cmd == `CMD_PRE) begin // see RQ12 RQ15
        for (k = 0; k < BANKS; k = k + 1)
          if (a[`AP_BIT] || ba == k[2:0]) begin
            open_q[k] <= 1'b0;
            rp_q[k]   <= T_RP;
          end
      end
      // Auto precharge ignored in pattern mode
      if (is_rd && a[`AP_BIT] && !pat_en) begin // see RQ22 RQ13
        open_q[ba] <= 1'b0;
        rp_q[ba]   <= T_RP;
      end
    end
  end
  // ==========================================
  // APB slave, one wait-free access
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr > `OFF_ERR_COUNT;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        if (paddr == `OFF_CTRL) prdata <= ctrl_q;
        else if (paddr == `OFF_STATUS) prdata <= {31'h0, cmd_error};
        else if (paddr == `OFF_BANK_OPEN) prdata <= {24'h0, open_q};
        else if (paddr == `OFF_ROW_SEL) prdata <= {29'h0, row_sel_q};
        else if (paddr == `OFF_ROW_DATA) prdata <= {18'h0, row_q[row_sel_q]};
        else if (paddr == `OFF_ERR_COUNT) prdata <= {16'h0, err_cnt_q};
      end
    end
  end
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) row_sel_q <= 3'h0;
    else if (apb_wr && paddr == `OFF_ROW_SEL) row_sel_q <= pwdata[2:0];
  end
  // ==========================================
  // Read data path
  read_burst_engine #(.DEPTH_LOG(2)) u_engine (
    .clock      (clock),
    .rst_b      (rst_b),
    .rd_push    (is_rd && (pat_en || open_q[ba])),
    .rd_latency (read_latency_cycles),
    .rd_full8   (full8),
    .rd_upper   (a[2]),
    .rd_pattern (pat_rd),
    .dq_oe      (dq_oe),
    .dq_out     (dq_out),
    .dqs_out    (dqs_out)
  );
endmodule // sdram_bank_read_calibration
`default_nettype wire

// ---- sim/sdram_cal_chk.sv ----
// Checker for command, read burst and register bus behaviour
`timescale 1ns/1ps
`default_nettype none
module sdram_cal_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // Command pins
  input wire logic        cs_b,
  input wire logic        ras_b,
  input wire logic        cas_b,
  input wire logic        we_b,
  // Read data pins
  input wire logic        dq_oe,
  input wire logic        dqs_out,
  // Register bus
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  // Illegal command flag
  input wire logic        cmd_error
);
  logic [5:0] rd_cnt_q;
  logic [5:0] run_q;
  wire        rd_cmd = ({cs_b, ras_b, cas_b, we_b} == 4'h5);
  // Cycles since the last read, length of the current data run
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_cnt_q <= 6'h3F;
      run_q    <= 6'h00;
    end else begin
      rd_cnt_q <= rd_cmd ? 6'h00 : ((rd_cnt_q == 6'h3F) ? rd_cnt_q : rd_cnt_q + 6'h01);
      run_q    <= dq_oe ? run_q + 6'h01 : 6'h00;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  a_ready_next: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  a_bad_addr: assert property (s_done ##0 (paddr > 8'h14) |-> pslverr) else $error("no pslverr");
  a_good_addr: assert property (s_done ##0 (paddr <= 8'h14) |-> !pslverr) else $error("pslverr");
  a_read_latency: assert property ($rose(dq_oe) |-> rd_cnt_q >= 6'h05 && rd_cnt_q <= 6'h14)
    else $error("burst start off");
  a_min_beats: assert property ($rose(dq_oe) |-> dq_oe [*4]) else $error("short burst");
  a_burst_whole: assert property ($fell(dq_oe) |-> run_q[1:0] == 2'h0)
    else $error("partial burst");
  a_strobe_alt: assert property (dq_oe && $past(dq_oe) |-> dqs_out != $past(dqs_out))
    else $error("strobe stuck");
  a_err_cause: assert property (cmd_error |-> !$past(cs_b, 2) || !$past(cs_b, 3))
    else $error("flag without command");
endmodule // sdram_cal_chk
bind sdram_bank_read_calibration sdram_cal_chk u_chk (.clock(clock), .rst_b(rst_b),
  .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b), .dq_oe(dq_oe), .dqs_out(dqs_out),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .cmd_error(cmd_error));
`default_nettype wire

// ---- sim/mem_ctrl_model.sv ----
// Memory controller model driving the command pins
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model (
  // Clock
  input  wire logic        clock,
  // Command pins
  output var  logic        cs_b,
  output var  logic        ras_b,
  output var  logic        cas_b,
  output var  logic        we_b,
  output var  logic [2:0]  bank_select,
  output var  logic [13:0] addr
);
  // Deselected at start
  initial begin
    {cs_b, ras_b, cas_b, we_b} = 4'hF;
    bank_select = 3'h0;
    addr = 14'h0000;
  end
  // One command, then deselect with flipped lines, then a spacing gap
  task automatic issue(input logic [3:0] op, input logic [2:0] ba, input logic [13:0] a,
                       input int gap);
    @(posedge clock);
    {cs_b, ras_b, cas_b, we_b} <= op;
    bank_select <= ba;
    addr <= a;
    @(posedge clock);
    {cs_b, ras_b, cas_b, we_b} <= 4'hF;
    bank_select <= ~ba;
    addr <= ~a;
    repeat (gap) @(posedge clock);
  endtask
endmodule // mem_ctrl_model
`default_nettype wire

// ---- sim/sdram_bank_read_calibration_tb.sv ----
// Testbench for the bank, read and calibration-pattern block
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_read_calibration_tb;
  logic        clock = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, cmd_error, dq_oe, dqs_out, cs_b, ras_b, cas_b, we_b, err;
  logic [15:0] dq_out;
  logic [2:0]  bank_select;
  logic [13:0] addr;
  int          n_errors = 0, num_checks = 0, n_flag = 0, i, k, n;
  // Pattern read rows: address with chop, autoclose and column bit 2, then beats
  logic [13:0] row_a [4] = '{14'h1000, 14'h1400, 14'h0000, 14'h0004};
  int          row_n [4] = '{8, 8, 4, 4};
  always #20 clock = ~clock;
  // Count illegal command pulses
  always @(posedge clock) if (cmd_error === 1'b1) n_flag++;
  sdram_bank_read_calibration u_dut (.clock(clock), .rst_b(rst_b), .cs_b(cs_b), .ras_b(ras_b),
    .cas_b(cas_b), .we_b(we_b), .bank_select(bank_select), .addr(addr), .dq_oe(dq_oe),
    .dq_out(dq_out), .dqs_out(dqs_out), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_error(cmd_error));
  mem_ctrl_model u_ctl (.clock(clock), .cs_b(cs_b), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
    .bank_select(bank_select), .addr(addr));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("Checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic timeout;
    n_errors++;
    $display("Error at %0t: wait ran out", $time);
    summarize();
  endtask
  // Register bus transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge clock); k++; end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Collect one burst and compare every beat
  task automatic burst(input int beats, input logic pat);
    k = 0;
    while (dq_oe !== 1'b1 && k < 40) begin @(posedge clock); k++; end
    if (dq_oe !== 1'b1) timeout();
    n = 0;
    while (dq_oe === 1'b1 && n < 9) begin
      check(dq_out, pat ? {16{n[0]}} : n[15:0]);
      n++;
      @(posedge clock);
    end
    check(n, beats);
  endtask
  initial begin
    repeat (3) @(posedge clock);
    check({dq_oe, dqs_out, cmd_error, pready}, 4'h0);
    rst_b <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h6);
    apb(1'b0, 8'h20, 32'h0);
    check(err, 1'b1);
    $display("Register test done");
    u_ctl.issue(4'h2, 3'h0, 14'h0400, 8);
    u_ctl.issue(4'h0, 3'h0, 14'h0001, 8);
    u_ctl.issue(4'h0, 3'h3, 14'h0004, 8);
    for (i = 0; i < 4; i++) begin
      u_ctl.issue(4'h5, i[2:0], row_a[i], 0);
      burst(row_n[i], 1'b1);
      $display("Pattern row %0d done", i);
    end
    u_ctl.issue(4'h0, 3'h3, 14'h0000, 8);
    u_ctl.issue(4'h3, 3'h2, 14'h0123, 4);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h4);
    u_ctl.issue(4'h5, 3'h2, 14'h1000, 0);
    burst(8, 1'b0);
    u_ctl.issue(4'h2, 3'h2, 14'h0000, 2);
    u_ctl.issue(4'h2, 3'h2, 14'h0000, 8);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    check(n_flag, 0);
    $display("Array test done");
    u_ctl.issue(4'h5, 3'h5, 14'h1000, 16);
    check(n_flag, 1);
    u_ctl.issue(4'h3, 3'h2, 14'h0010, 4);
    u_ctl.issue(4'h3, 3'h2, 14'h0020, 16);
    check(n_flag, 2);
    $display("Illegal command test done");
    summarize();
  end
endmodule // sdram_bank_read_calibration_tb
`default_nettype wire
